// ### include/rds_defs.svh
// register offsets, field positions and reset values of the sweep controller
// assumes inclusion by the package and the design file, byte addresses on Avalon-MM
`ifndef RDS_DEFS_SVH
`define RDS_DEFS_SVH

// byte offsets of the register words
`define RDS_OFS_CTRL 8'h00
`define RDS_OFS_DAC_LOW 8'h04
`define RDS_OFS_DAC_HIGH 8'h08
`define RDS_OFS_STEP 8'h0c
`define RDS_OFS_ZONE_LOW 8'h10
`define RDS_OFS_ZONE_HIGH 8'h14
`define RDS_OFS_BASE_PPS 8'h18
`define RDS_OFS_DENSE_PPS 8'h1c
`define RDS_OFS_SHIFT 8'h20
`define RDS_OFS_SETTLE 8'h24
`define RDS_OFS_HOLD 8'h28
`define RDS_OFS_PASSES 8'h2c
`define RDS_OFS_STATUS 8'h30
`define RDS_OFS_DAC_NOW 8'h34

// control word fields
`define RDS_CTRL_START 0
`define RDS_CTRL_ABORT 1
`define RDS_CTRL_MODE_LO 4
`define RDS_CTRL_MODE_HI 6
`define RDS_CTRL_AUTO_PD 8
`define RDS_CTRL_MAN_PD 9
`define RDS_CTRL_BYPASS 12
`define RDS_CTRL_BYP_LEVEL 13

// status word fields
`define RDS_ST_RUN 15
`define RDS_ST_GATE 14
`define RDS_ST_DENSE 13
`define RDS_ST_DOWN 12
`define RDS_ST_STATE_LO 8
`define RDS_ST_STATE_HI 10

// widths and reset values
`define RDS_DAC_W 13
`define RDS_STATUS_W 16
`define RDS_SHIFT_MAX 4'h9
`define RDS_DAC_FULL 13'h1fff
`define RDS_RST_PPS 24'h000001
`define RDS_RST_WAIT 24'h000004
`define RDS_RST_PASSES 8'h01
`define RDS_FRAME_DEPTH 512
`define RDS_SAMPLE_W 32

`endif

// ### include/rds_pkg.sv
// types shared by the sweep controller
// assumes rds_defs.svh is on the include path
`include "rds_defs.svh"
package rds_pkg;

  // sweep sequencer states
  typedef enum logic [2:0] {
    RDS_IDLE = 3'b000,
    RDS_SETUP = 3'b001,
    RDS_SETTLE = 3'b010,
    RDS_AVERAGE = 3'b011,
    RDS_HOLD = 3'b100,
    RDS_CHECK = 3'b101
  } rds_state_e;

  // six sweep modes
  typedef enum logic [2:0] {
    RDS_ONCE_UP = 3'b000,
    RDS_ONCE_DOWN = 3'b001,
    RDS_REPEAT_UP = 3'b010,
    RDS_REPEAT_DOWN = 3'b011,
    RDS_BIDIR_UP = 3'b100,
    RDS_BIDIR_DOWN = 3'b101
  } rds_mode_e;

  // configuration held in registers
  typedef struct packed {
    logic [2:0] mode;
    logic autoPd;
    logic manualPd;
    logic bypass;
    logic bypassLevel;
    logic [`RDS_DAC_W-1:0] dacLow;
    logic [`RDS_DAC_W-1:0] dacHigh;
    logic [`RDS_DAC_W-1:0] step;
    logic [`RDS_DAC_W-1:0] zoneLow;
    logic [`RDS_DAC_W-1:0] zoneHigh;
    logic [23:0] basePps;
    logic [23:0] densePps;
    logic [3:0] shift;
    logic [23:0] settle;
    logic [23:0] hold;
    logic [7:0] passes;
  } rds_cfg_s;

  // outputs toward dac, sampler and thresholder
  typedef struct packed {
    logic [`RDS_DAC_W-1:0] dacCode;
    logic samplerGate;
    logic denseZoneFlag;
    logic [3:0] accumShift;
    logic thresholderPowerdown;
    logic frameDone;
  } rds_drive_s;

endpackage

// ### design/rds_sweep_ctrl.sv
// sweep controller: steps the 13-bit quantizer reference dac, gates the sampler
// assumes an Avalon-MM master on ref_clk and strobe pins from the serial master
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`include "rds_defs.svh"
module rds_sweep_ctrl
  import rds_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic runStartPin,
  input wire logic abortPin,
  output rds_drive_s drive,
  output logic runActive,
  output logic [`RDS_STATUS_W-1:0] statusWord
);

  // register state
  rds_cfg_s cfg_reg;
  rds_state_e state_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic swStart_reg, swAbort_reg;
  logic [1:0] startSync_reg, abortSync_reg;
  logic startSeen_reg, abortSeen_reg;
  logic [`RDS_DAC_W-1:0] dac_reg;
  logic down_reg, gate_reg, dense_reg;
  logic [3:0] shiftOut_reg;
  logic run_reg, pd_reg, done_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0] passLeft_reg;

  // decoded events
  logic busReq, wrHit, startEv, abortEv, inZone;
  logic [CNT_W-1:0] pulseTarget;
  logic [`RDS_DAC_W:0] upNext, downNext;
  logic pastBound, modeDown, modeRepeat, modeBidir;
  logic [31:0] regImage, wrMerged;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // one wait state: waitrequest drops on the cycle after the request appears
  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = ~ack_reg;
  assign avs_readdata = rdata_reg;
  assign wrHit = avs_write & ack_reg;
  assign wrMerged = merge(regImage, avs_writedata, avs_byteenable);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busReq & ~ack_reg;
    end
  end

  // configuration writes, applied on the edge where waitrequest is low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= '0;
      cfg_reg.dacHigh <= `RDS_DAC_FULL;
      cfg_reg.step <= `RDS_DAC_W'(1);
      cfg_reg.basePps <= `RDS_RST_PPS;
      cfg_reg.densePps <= `RDS_RST_PPS;
      cfg_reg.settle <= `RDS_RST_WAIT;
      cfg_reg.hold <= `RDS_RST_WAIT;
      cfg_reg.passes <= `RDS_RST_PASSES;
    end else if (wrHit) begin
      if (avs_address == `RDS_OFS_CTRL) begin
        cfg_reg.mode <= wrMerged[`RDS_CTRL_MODE_HI:`RDS_CTRL_MODE_LO];
        cfg_reg.autoPd <= wrMerged[`RDS_CTRL_AUTO_PD];
        cfg_reg.manualPd <= wrMerged[`RDS_CTRL_MAN_PD];
        cfg_reg.bypass <= wrMerged[`RDS_CTRL_BYPASS];
        cfg_reg.bypassLevel <= wrMerged[`RDS_CTRL_BYP_LEVEL];
      end else if (avs_address == `RDS_OFS_DAC_LOW) cfg_reg.dacLow <= wrMerged[12:0];
      else if (avs_address == `RDS_OFS_DAC_HIGH) cfg_reg.dacHigh <= wrMerged[12:0];
      else if (avs_address == `RDS_OFS_STEP) cfg_reg.step <= wrMerged[12:0];
      else if (avs_address == `RDS_OFS_ZONE_LOW) cfg_reg.zoneLow <= wrMerged[12:0];
      else if (avs_address == `RDS_OFS_ZONE_HIGH) cfg_reg.zoneHigh <= wrMerged[12:0];
      else if (avs_address == `RDS_OFS_BASE_PPS) cfg_reg.basePps <= wrMerged[23:0];
      else if (avs_address == `RDS_OFS_DENSE_PPS) cfg_reg.densePps <= wrMerged[23:0];
      else if (avs_address == `RDS_OFS_SHIFT) cfg_reg.shift <= wrMerged[3:0];
      else if (avs_address == `RDS_OFS_SETTLE) cfg_reg.settle <= wrMerged[23:0];
      else if (avs_address == `RDS_OFS_HOLD) cfg_reg.hold <= wrMerged[23:0];
      else if (avs_address == `RDS_OFS_PASSES) cfg_reg.passes <= wrMerged[7:0];
    end
  end

  // control word image as it reads back
  function automatic logic [31:0] ctrlWord();
    logic [31:0] w;
    w = '0;
    w[`RDS_CTRL_MODE_HI:`RDS_CTRL_MODE_LO] = cfg_reg.mode;
    w[`RDS_CTRL_AUTO_PD] = cfg_reg.autoPd;
    w[`RDS_CTRL_MAN_PD] = cfg_reg.manualPd;
    w[`RDS_CTRL_BYPASS] = cfg_reg.bypass;
    w[`RDS_CTRL_BYP_LEVEL] = cfg_reg.bypassLevel;
    return w;
  endfunction

  // software strobes: self-clearing one-cycle pulses from the control word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      swStart_reg <= 1'b0;
      swAbort_reg <= 1'b0;
    end else begin
      swStart_reg <= wrHit & (avs_address == `RDS_OFS_CTRL) & avs_byteenable[0]
                     & avs_writedata[`RDS_CTRL_START];
      swAbort_reg <= wrHit & (avs_address == `RDS_OFS_CTRL) & avs_byteenable[0]
                     & avs_writedata[`RDS_CTRL_ABORT];
    end
  end

  // strobe pins from the serial side: two flops, then rising edge detect
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      startSync_reg <= 2'h0;
      abortSync_reg <= 2'h0;
      startSeen_reg <= 1'b0;
      abortSeen_reg <= 1'b0;
    end else begin
      startSync_reg <= {startSync_reg[0], runStartPin};
      abortSync_reg <= {abortSync_reg[0], abortPin};
      startSeen_reg <= startSync_reg[1];
      abortSeen_reg <= abortSync_reg[1];
    end
  end

  // the serial master raises a pin at the strobe edge with length zero
  assign startEv = swStart_reg | (startSync_reg[1] & ~startSeen_reg);
  assign abortEv = swAbort_reg | (abortSync_reg[1] & ~abortSeen_reg);

  // mode decode
  assign modeDown = cfg_reg.mode[0];
  assign modeRepeat = (cfg_reg.mode == RDS_REPEAT_UP) | (cfg_reg.mode == RDS_REPEAT_DOWN);
  assign modeBidir = (cfg_reg.mode == RDS_BIDIR_UP) | (cfg_reg.mode == RDS_BIDIR_DOWN);

  // zone and pulse count selection
  assign inZone = (dac_reg >= cfg_reg.zoneLow) & (dac_reg <= cfg_reg.zoneHigh);
  always_comb begin
    if (cfg_reg.bypass & cfg_reg.bypassLevel) begin
      pulseTarget = CNT_W'(cfg_reg.densePps);
    end else if (inZone) begin
      pulseTarget = CNT_W'(cfg_reg.densePps);
    end else begin
      pulseTarget = CNT_W'(cfg_reg.basePps);
    end
  end

  // next code and end-of-pass test, one bit wider to catch wrap
  assign upNext = {1'b0, dac_reg} + {1'b0, cfg_reg.step};
  assign downNext = {1'b0, dac_reg} - {1'b0, cfg_reg.step};
  assign pastBound = down_reg ? (downNext[`RDS_DAC_W] | (downNext < {1'b0, cfg_reg.dacLow}))
                              : (upNext > {1'b0, cfg_reg.dacHigh});

  // sequencer state, abort wins over everything
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= RDS_IDLE;
    end else if (abortEv) begin
      state_reg <= RDS_IDLE;
    end else begin
      case (state_reg)
        RDS_IDLE: begin
          if (startEv) begin
            state_reg <= RDS_SETUP;
          end
        end
        RDS_SETUP: begin
          state_reg <= RDS_SETTLE;
        end
        RDS_SETTLE: begin
          if (cnt_reg >= CNT_W'(cfg_reg.settle)) begin
            state_reg <= RDS_AVERAGE;
          end
        end
        RDS_AVERAGE: begin
          if (cnt_reg >= pulseTarget - CNT_W'(1)) begin
            state_reg <= RDS_HOLD;
          end
        end
        RDS_HOLD: begin
          if (cnt_reg >= CNT_W'(cfg_reg.hold)) begin
            state_reg <= RDS_CHECK;
          end
        end
        RDS_CHECK: begin
          if (!pastBound) begin
            state_reg <= RDS_SETTLE;
          end else if (passLeft_reg > 8'h01) begin
            state_reg <= RDS_SETUP;
          end else begin
            state_reg <= RDS_IDLE;
          end
        end
        default: begin
          state_reg <= RDS_IDLE;
        end
      endcase
    end
  end

  // phase counter, cleared on each state change
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (abortEv || state_reg == RDS_IDLE || state_reg == RDS_SETUP
                 || state_reg == RDS_CHECK) begin
      cnt_reg <= '0;
    end else if ((state_reg == RDS_SETTLE && cnt_reg >= CNT_W'(cfg_reg.settle))
                 || (state_reg == RDS_AVERAGE && cnt_reg >= pulseTarget - CNT_W'(1))
                 || (state_reg == RDS_HOLD && cnt_reg >= CNT_W'(cfg_reg.hold))) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // direction and remaining passes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      down_reg <= 1'b0;
      passLeft_reg <= `RDS_RST_PASSES;
    end else if (state_reg == RDS_IDLE && startEv && !abortEv) begin
      down_reg <= modeDown;
      passLeft_reg <= modeRepeat | modeBidir ? cfg_reg.passes : `RDS_RST_PASSES;
    end else if (state_reg == RDS_CHECK && pastBound && passLeft_reg > 8'h01 && !abortEv) begin
      passLeft_reg <= passLeft_reg - 8'h01;
      if (modeBidir) begin
        down_reg <= ~down_reg;
      end
    end
  end

  // dac code: initial bound at setup, stepped at check
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dac_reg <= '0;
    end else if (state_reg == RDS_SETUP && !abortEv) begin
      dac_reg <= down_reg ? cfg_reg.dacHigh : cfg_reg.dacLow;
    end else if (state_reg == RDS_CHECK && !pastBound && !abortEv) begin
      dac_reg <= down_reg ? downNext[`RDS_DAC_W-1:0]
                          : upNext[`RDS_DAC_W-1:0];
    end
  end

  // sampler gate high only while averaging, so dac updates see it low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gate_reg <= 1'b0;
    end else if (abortEv) begin
      gate_reg <= 1'b0;
    end else if (state_reg == RDS_SETTLE && cnt_reg >= CNT_W'(cfg_reg.settle)) begin
      gate_reg <= 1'b1;
    end else if (state_reg == RDS_AVERAGE && cnt_reg >= pulseTarget - CNT_W'(1)) begin
      gate_reg <= 1'b0;
    end
  end

  // focus flag and accumulator weight; outside the zone samples weigh 2^shift, with shift saturating at 9
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dense_reg <= 1'b0;
      shiftOut_reg <= 4'h0;
    end else begin
      dense_reg <= inZone & (state_reg != RDS_IDLE) & ~(cfg_reg.bypass & cfg_reg.bypassLevel);
      if (cfg_reg.bypass & cfg_reg.bypassLevel) begin
        shiftOut_reg <= 4'h0;
      end else if (!inZone) begin
        shiftOut_reg <= (cfg_reg.shift > `RDS_SHIFT_MAX) ? `RDS_SHIFT_MAX : cfg_reg.shift;
      end else begin
        shiftOut_reg <= 4'h0;
      end
    end
  end

  // run flag and frame-ready pulse, both on ref_clk
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (abortEv) begin
        run_reg <= 1'b0;
      end else if (state_reg == RDS_SETUP) begin
        run_reg <= 1'b1;
      end else if (state_reg == RDS_CHECK && pastBound && passLeft_reg <= 8'h01) begin
        run_reg <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end

  // thresholder powerdown follows the inverted run flag when automatic mode is set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pd_reg <= 1'b0;
    end else begin
      pd_reg <= cfg_reg.manualPd | (cfg_reg.autoPd & ~run_reg);
    end
  end

  // read data captured from the image while waitrequest is high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (avs_read & ~ack_reg) begin
      rdata_reg <= regImage;
    end
  end

  // register image at the bus address, shared by reads and write lane merging
  always_comb begin
    regImage = '0;
    if (avs_address == `RDS_OFS_CTRL) regImage = ctrlWord();
    else if (avs_address == `RDS_OFS_DAC_LOW) regImage = 32'(cfg_reg.dacLow);
    else if (avs_address == `RDS_OFS_DAC_HIGH) regImage = 32'(cfg_reg.dacHigh);
    else if (avs_address == `RDS_OFS_STEP) regImage = 32'(cfg_reg.step);
    else if (avs_address == `RDS_OFS_ZONE_LOW) regImage = 32'(cfg_reg.zoneLow);
    else if (avs_address == `RDS_OFS_ZONE_HIGH) regImage = 32'(cfg_reg.zoneHigh);
    else if (avs_address == `RDS_OFS_BASE_PPS) regImage = 32'(cfg_reg.basePps);
    else if (avs_address == `RDS_OFS_DENSE_PPS) regImage = 32'(cfg_reg.densePps);
    else if (avs_address == `RDS_OFS_SHIFT) regImage = 32'(cfg_reg.shift);
    else if (avs_address == `RDS_OFS_SETTLE) regImage = 32'(cfg_reg.settle);
    else if (avs_address == `RDS_OFS_HOLD) regImage = 32'(cfg_reg.hold);
    else if (avs_address == `RDS_OFS_PASSES) regImage = 32'(cfg_reg.passes);
    else if (avs_address == `RDS_OFS_STATUS) regImage = 32'(statusWord);
    else if (avs_address == `RDS_OFS_DAC_NOW) regImage = 32'(dac_reg);
  end

  // status word, msb is the run flag, shifted out msb first by the serial side
  always_comb begin
    statusWord = '0;
    statusWord[`RDS_ST_RUN] = run_reg;
    statusWord[`RDS_ST_GATE] = gate_reg;
    statusWord[`RDS_ST_DENSE] = dense_reg;
    statusWord[`RDS_ST_DOWN] = down_reg;
    statusWord[`RDS_ST_STATE_HI:`RDS_ST_STATE_LO] = state_reg;
    statusWord[7:0] = passLeft_reg;
  end

  // outward drive
  assign runActive = run_reg;
  assign drive.dacCode = dac_reg;
  assign drive.samplerGate = gate_reg;
  assign drive.denseZoneFlag = dense_reg;
  assign drive.accumShift = shiftOut_reg;
  assign drive.thresholderPowerdown = pd_reg;
  assign drive.frameDone = done_reg;

endmodule

// ### test/rds_sweep_ctrl_asserts.sv
// concurrent checks on the sweep controller ports
// assumes rds_pkg compiled first; bound onto every rds_sweep_ctrl instance
`include "rds_defs.svh"
module rds_sweep_ctrl_chk
  import rds_pkg::*;
#(
  parameter int CNT_W = 24
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic runStartPin,
  input wire logic abortPin,
  input wire rds_drive_s drive,
  input wire logic runActive,
  input wire logic [`RDS_STATUS_W-1:0] statusWord
);
  timeunit 1ns;
  timeprecision 1ps;
  // every check runs on the core clock and rests during reset
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  chk_start_raises_run: assert property (
    $rose(runStartPin) && !runActive && !abortPin |-> ##[2:10] runActive)
    else $error("run flag did not rise after start");
  chk_frame_ends_run: assert property (
    $rose(drive.frameDone) |-> $fell(runActive))
    else $error("frame done without run flag falling");
  chk_frame_one_cycle: assert property (
    drive.frameDone |=> !drive.frameDone)
    else $error("frame done longer than one cycle");
  chk_abort_to_idle: assert property (
    $rose(abortPin) |-> ##[1:8] !runActive && !drive.samplerGate)
    else $error("abort did not stop the sweep");
  chk_gate_code_still: assert property (
    $changed(drive.dacCode) |-> !drive.samplerGate)
    else $error("dac code moved while sampler gated on");
  chk_gate_needs_run: assert property (
    drive.samplerGate |-> runActive)
    else $error("sampler gated on outside a run");
  chk_hold_after_gate: assert property (
    $fell(drive.samplerGate) |-> (!drive.samplerGate) [*3])
    else $error("no hold after averaging");
  chk_code_in_run: assert property (
    $changed(drive.dacCode) |-> runActive)
    else $error("dac code moved while idle");
  chk_status_run_bit: assert property (
    statusWord[`RDS_ST_RUN] == runActive)
    else $error("status msb differs from run flag");
endmodule
bind rds_sweep_ctrl rds_sweep_ctrl_chk #(.CNT_W(CNT_W)) rds_sweep_ctrl_chk_i (
  .ref_clk(ref_clk), .reset(reset), .runStartPin(runStartPin), .abortPin(abortPin),
  .drive(drive), .runActive(runActive), .statusWord(statusWord));

// ### test/rds_serial_master.sv
// model of the external serial master that fires the start and abort strobes
// assumes the bench requests a strobe with a one-cycle pulse on ref_clk
module rds_serial_master (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic startReq,
  input wire logic abortReq,
  output logic runStartPin,
  output logic abortPin
);
  timeunit 1ns;
  timeprecision 1ps;
  int sCnt;
  int aCnt;
  // a zero-length strobe command ends with a pin pulse held four cycles
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sCnt <= 0;
      aCnt <= 0;
      runStartPin <= 1'b0;
      abortPin <= 1'b0;
    end else begin
      sCnt <= startReq ? 4 : (sCnt != 0 ? sCnt - 1 : 0);
      aCnt <= abortReq ? 4 : (aCnt != 0 ? aCnt - 1 : 0);
      runStartPin <= sCnt != 0;
      abortPin <= aCnt != 0;
    end
  end
endmodule

// ### test/rds_sweep_ctrl_bench.sv
// self-checking bench for the sweep controller: register tasks and sweep runs
// assumes the design, package, serial master model and checker are compiled
module rds_sweep_ctrl_bench;
  import rds_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic startReq, abortReq, runStartPin, abortPin, runActive;
  logic [15:0] statusWord;
  logic [12:0] gCode;
  logic [12:0] codeQ[$];
  rds_drive_s drive;
  int n_errors, n_checks, gLen, frames, sinceLoad;
  bit bypG;
  int lenQ[$];
  logic [7:0] rstA[8] = '{8'h08, 8'h0c, 8'h18, 8'h1c, 8'h24, 8'h28, 8'h2c, 8'h3c};
  logic [31:0] rstV[8] = '{32'h1fff, 32'h1, 32'h1, 32'h1, 32'h4, 32'h4, 32'h1, 32'h0};
  logic [7:0] cfgA[11] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
                           8'h28, 8'h2c};
  logic [31:0] cfgV[11] = '{10, 18, 4, 14, 14, 2, 4, 1, 2, 2, 2};

  rds_sweep_ctrl #(.CNT_W(24)) rds_sweep_ctrl_i (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .runStartPin(runStartPin), .abortPin(abortPin),
    .drive(drive), .runActive(runActive), .statusWord(statusWord));
  rds_serial_master rds_serial_master_i (.ref_clk(ref_clk), .reset(reset),
    .startReq(startReq), .abortReq(abortReq), .runStartPin(runStartPin), .abortPin(abortPin));

  // 40 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // avalon access: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    rd = avs_readdata;
    if (n >= 50) chk(1, 0, "bus timeout");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    while (runActive !== lvl && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 5000) chk(1, 0, "run flag wait");
  endtask

  function automatic logic [31:0] ctrl(input int mode, input bit byp);
    return (32'(mode) << 4) | 32'h101 | (byp ? 32'h3000 : 32'h0);
  endfunction

  // one sweep in the given mode, then steps and pulse counts compared
  task automatic run_mode(input int mode, input bit byp);
    logic [12:0] exp[$];
    int np, up;
    lenQ.delete();
    codeQ.delete();
    frames = 0;
    bypG = byp;
    np = (mode >= 2 && mode <= 5) ? 2 : 1;
    for (int p = 0; p < np; p++) begin
      up = ((mode % 2) == 0) ^ (mode >= 4 && p % 2 == 1);
      for (int k = 0; k < 3; k++) exp.push_back(up ? 13'(10 + 4 * k) : 13'(18 - 4 * k));
    end
    bus(1, 8'h00, ctrl(mode, byp));
    wait_run(1);
    wait_run(0);
    repeat (3) @(posedge ref_clk);
    chk(frames, 1, "frame done count");
    chk(codeQ.size(), exp.size(), "step count");
    foreach (exp[i]) begin
      chk(codeQ[i], exp[i], "dac code");
      chk(lenQ[i], (byp || exp[i] == 14) ? 4 : 2, "pulse count");
    end
    chk(drive.thresholderPowerdown, 1, "auto powerdown when idle");
  endtask

  // monitor: length and code of each gated averaging phase, frame pulses
  always @(posedge ref_clk) begin
    if (!reset && drive.frameDone === 1'b1) frames++;
    // cycles since the code was loaded (setup or check edge), settle is 2
    if (statusWord[10:8] == RDS_SETUP || statusWord[10:8] == RDS_CHECK) sinceLoad = 0;
    else sinceLoad++;
    if (!reset && drive.samplerGate === 1'b1) begin
      if (gLen == 0) chk(sinceLoad, 4, "settle before averaging");
      gLen++;
      gCode = drive.dacCode;
      chk(drive.denseZoneFlag, !bypG && gCode == 14, "focus flag");
      chk(drive.accumShift, (bypG || gCode == 14) ? 0 : 1, "outside weight");
      if (drive.thresholderPowerdown !== 1'b0) chk(1, 0, "powerdown during run");
    end else if (gLen != 0) begin
      lenQ.push_back(gLen);
      codeQ.push_back(gCode);
      gLen = 0;
    end
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    reset = 1'b1;
    {avs_read, avs_write, startReq, abortReq} = 4'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk($bits(drive.dacCode), 13, "dac code width");
    foreach (rstA[i]) begin
      bus(0, rstA[i], 32'h0);
      chk(rd, rstV[i], "reset value or unmapped read");
    end
    foreach (cfgA[i]) bus(1, cfgA[i], cfgV[i]);
    for (int m = 0; m < 6; m++) run_mode(m, 0);
    run_mode(0, 1);
    bus(1, 8'h1c, 32'd200);
    startReq <= 1'b1;
    @(posedge ref_clk);
    startReq <= 1'b0;
    wait_run(1);
    chk(statusWord[15], 1, "status run bit");
    repeat (30) @(posedge ref_clk);
    chk(drive.samplerGate, 1, "averaging under way");
    abortReq <= 1'b1;
    @(posedge ref_clk);
    abortReq <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk(runActive, 0, "abort stops run");
    chk(statusWord[10:8], RDS_IDLE, "abort returns idle");
    chk(drive.samplerGate, 0, "gate off after abort");
    finish_test();
  end
endmodule
